// ==== vpc_pkg.sv ====
// Constants shared by the video processing control/status register bank.
// Assumes one device clock and a synchronous active-low reset.
`default_nettype none

package vpc_pkg;

  localparam int          VPC_ADDR_W   = 12;
  localparam int          VPC_DATA_W   = 16;
  localparam int          VPC_FLAG_W   = 15;
  localparam int          VPC_CSUM_W   = 10;

  // Register offsets
  localparam logic [11:0] VPC_OFS_CTRL = 12'h000;
  localparam logic [11:0] VPC_OFS_STAT = 12'h001;

  // Control register reset, writable bits (bit 13 reads zero)
  localparam logic [15:0] VPC_CTRL_RESET = 16'h0200;
  localparam logic [15:0] VPC_CTRL_WMASK = 16'hDFFF;

  // Control field positions
  localparam int VPC_B_DELAY_LINE_ON      = 14;
  localparam int VPC_B_KEEP_CHECK_FLAGS   = 12;
  localparam int VPC_B_ANC_INSERT_OFF     = 11;
  localparam int VPC_B_LEVEL_A_TO_B_OFF   = 9;
  localparam int VPC_B_H_TIMING_SMPTE     = 8;
  localparam int VPC_B_PAYLOAD_ID_OFF     = 6;
  localparam int VPC_B_BAD_WORD_FIXUP_OFF = 5;
  localparam int VPC_B_CHECK_CRC_OFF      = 4;
  localparam int VPC_B_ANC_CSUM_OFF       = 3;
  localparam int VPC_B_LINE_CRC_OFF       = 2;
  localparam int VPC_B_LINE_NUMBER_OFF    = 1;
  localparam int VPC_B_TIMING_REF_OFF     = 0;

  // Status field positions; bits 15..7 read zero
  localparam int VPC_S_TIMING_REF_FAULT   = 6;
  localparam int VPC_S_CHECK_PACKET_SUM   = 5;
  localparam int VPC_S_ANC_SUM            = 4;
  localparam int VPC_S_FORMAT             = 3;
  localparam int VPC_S_RASTER             = 2;
  localparam int VPC_S_PAYLOAD_ID_MISSING = 1;
  localparam int VPC_S_PLL_LOCK           = 0;
  localparam logic [15:0] VPC_STAT_RESET = 16'h0000;

  // Checksum values that never raise a fault
  localparam logic [9:0]  VPC_CSUM_LOW_TOP  = 10'h003;
  localparam logic [9:0]  VPC_CSUM_HIGH_BOT = 10'h3FC;

endpackage : vpc_pkg

`default_nettype wire

// ==== vpc_reg_if.sv ====
// Carrier between the register bank top and its two storage modules.
// Assumes all three run on the same device clock.
`default_nettype none

interface vpc_reg_if;
  import vpc_pkg::*;
  logic                  wr_en;
  logic [VPC_DATA_W-1:0] wr_data;
  logic [VPC_DATA_W-1:0] ctrl;
  logic [VPC_DATA_W-1:0] stat;

  modport hub       (output wr_en, output wr_data,
                     input  ctrl,  input  stat);
  modport ctrl_side (input  wr_en, input  wr_data, output ctrl);
  modport stat_side (output stat);
endinterface : vpc_reg_if

`default_nettype wire

// ==== vpc_ctrl_reg.sv ====
// Video processing control register storage.
// Assumes the top qualifies wr_en with the control register offset.
`default_nettype none

module vpc_ctrl_reg
  import vpc_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rstn,
  // Register carrier
  vpc_reg_if.ctrl_side rif
);

  logic [VPC_DATA_W-1:0] ctrl_q;

  // Read-only bit 13 never takes host data
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= VPC_CTRL_RESET; // see (RULE4)
    end else if (rif.wr_en) begin
      ctrl_q <= (rif.wr_data & VPC_CTRL_WMASK)
              | (ctrl_q & ~VPC_CTRL_WMASK); // see (RULE20)
    end
  end

  assign rif.ctrl = ctrl_q;

endmodule : vpc_ctrl_reg

`default_nettype wire

// ==== vpc_stat_mon.sv ====
// Processing error status collection.
// Assumes video-path inputs are on clk; pll_locked comes from a pin.
`default_nettype none

module vpc_stat_mon
  import vpc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Video path events, same clock
  input  wire logic                  timing_ref_protect_fault,
  input  wire logic                  csum_word_valid,
  input  wire logic                  csum_in_check_packet,
  input  wire logic [VPC_CSUM_W-1:0] csum_received,
  input  wire logic [VPC_CSUM_W-1:0] csum_computed,
  input  wire logic                  format_unknown,
  input  wire logic                  raster_mismatch,
  input  wire logic                  payload_id_absent,
  // Asynchronous PLL lock pin
  input  wire logic                  pll_locked,
  // Register carrier
  vpc_reg_if.stat_side               rif
);

  function automatic logic csum_protected(input logic [VPC_CSUM_W-1:0] v);
    csum_protected = (v <= VPC_CSUM_LOW_TOP) || (v >= VPC_CSUM_HIGH_BOT);
  endfunction : csum_protected

  logic lock_s1_q, lock_s2_q, lock_s3_q, locked_q;
  logic ancillary_sum_fault_q, check_packet_sum_fault_q;
  logic timing_ref_protect_fault_q, format_q, raster_q;
  logic payload_id_missing_flag_q;
  logic sum_bad;

  // Protected checksum values are never flagged
  assign sum_bad = (csum_received != csum_computed)
                 && !csum_protected(csum_received); // see (RULE15)

  // Three-stage lock synchroniser
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_s1_q <= 1'b1;
      lock_s2_q <= 1'b1;
      lock_s3_q <= 1'b1;
    end else begin
      lock_s1_q <= pll_locked;
      lock_s2_q <= lock_s1_q;
      lock_s3_q <= lock_s2_q;
    end
  end

  // Change accepted only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      locked_q <= 1'b1;
    end else if (lock_s2_q == lock_s3_q) begin
      locked_q <= lock_s3_q; // see (RULE19)
    end
  end

  // Both sum flags refresh on every checksum word they watch
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ancillary_sum_fault_q    <= 1'b0;
      check_packet_sum_fault_q <= 1'b0;
    end else if (csum_word_valid) begin
      ancillary_sum_fault_q <= sum_bad; // see (RULE13)
      if (csum_in_check_packet) begin
        check_packet_sum_fault_q <= sum_bad; // see (RULE14)
      end
    end
  end

  // Level conditions follow the video path
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timing_ref_protect_fault_q <= 1'b0;
      format_q                   <= 1'b0;
      raster_q                   <= 1'b0;
      payload_id_missing_flag_q  <= 1'b0;
    end else begin
      timing_ref_protect_fault_q <= timing_ref_protect_fault; // see (RULE12)
      format_q                   <= format_unknown; // see (RULE16)
      raster_q                   <= raster_mismatch; // see (RULE17)
      payload_id_missing_flag_q  <= payload_id_absent; // see (RULE18)
    end
  end

  always_comb begin
    rif.stat = VPC_STAT_RESET;
    rif.stat[VPC_S_TIMING_REF_FAULT]   = timing_ref_protect_fault_q;
    rif.stat[VPC_S_CHECK_PACKET_SUM]   = check_packet_sum_fault_q;
    rif.stat[VPC_S_ANC_SUM]            = ancillary_sum_fault_q;
    rif.stat[VPC_S_FORMAT]             = format_q;
    rif.stat[VPC_S_RASTER]             = raster_q;
    rif.stat[VPC_S_PAYLOAD_ID_MISSING] = payload_id_missing_flag_q;
    rif.stat[VPC_S_PLL_LOCK]           = !locked_q;
  end

endmodule : vpc_stat_mon

`default_nettype wire

// ==== vpc_regs.sv ====
// Control and status register bank of the transmit video processing path.
// Assumes a host port on the device clock and video logic beside it.
//
// Overview of operation
// (RULE1) Control bit 14 high turns the delay line delay on.
// (RULE2) Bit 12 high keeps incoming check flags, low uses programmed flags.
// (RULE3) Bit 11 high disables ancillary data insertion.
// (RULE4) Bit 9 high disables Level A to B conversion; resets to one.
// (RULE5) Bit 8 picks active-picture (low) or standard (high) H timing.
// (RULE6) Bit 6 high stops payload identifier packet insertion.
// (RULE7) Bit 5 high disables illegal video word remapping.
// (RULE8) Bit 4 high disables check CRC correction and insertion.
// (RULE9) Bit 3 high stops ancillary checksum word insertion.
// (RULE10) Bit 2 high stops line CRC, bit 1 high stops line numbers.
// (RULE11) Bit 0 high stops timing reference word insertion.
// (RULE12) Status bit 6 shows a timing reference protection error.
// (RULE13) Status bit 4 shows checksum error, refreshed on each checksum word.
// (RULE14) Status bit 5 same, but refreshed only inside check packets.
// (RULE15) Checksums 000h-003h and 3FCh-3FFh never raise the flag.
// (RULE16) Status bit 3 shows an unrecognised incoming video standard.
// (RULE17) Status bit 2 shows raster disagreeing with payload identifier.
// (RULE18) Status bit 1 shows no payload identifier in incoming video.
// (RULE19) Status bit 0 shows a PLL lock error.
// (RULE20) Writes to read-only and reserved read-only bits are ignored.
`default_nettype none

module vpc_regs
  import vpc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Host register port
  input  wire logic                  host_wr,
  input  wire logic                  host_rd,
  input  wire logic [VPC_ADDR_W-1:0] host_addr,
  input  wire logic [VPC_DATA_W-1:0] host_wdata,
  output logic      [VPC_DATA_W-1:0] host_rdata,
  output logic                       host_rvalid,
  // Video path status
  input  wire logic                  timing_ref_protect_fault,
  input  wire logic                  csum_word_valid,
  input  wire logic                  csum_in_check_packet,
  input  wire logic [VPC_CSUM_W-1:0] csum_received,
  input  wire logic [VPC_CSUM_W-1:0] csum_computed,
  input  wire logic                  format_unknown,
  input  wire logic                  raster_mismatch,
  input  wire logic                  payload_id_absent,
  input  wire logic                  pll_locked,
  // Check flag sources
  input  wire logic [VPC_FLAG_W-1:0] incoming_check_flags,
  input  wire logic [VPC_FLAG_W-1:0] programmed_check_flags,
  output logic      [VPC_FLAG_W-1:0] outgoing_check_flags,
  // Processing controls
  output logic                       delay_line_on,
  output logic                       keep_incoming_check_flags,
  output logic                       ancillary_insert_off,
  output logic                       level_a_to_b_off,
  output logic                       h_timing_smpte,
  output logic                       payload_id_insert_off,
  output logic                       bad_word_fixup_off,
  output logic                       error_check_crc_insert_off,
  output logic                       ancillary_checksum_insert_off,
  output logic                       line_check_word_insert_off,
  output logic                       line_number_insert_off,
  output logic                       timing_ref_insert_off
);

  vpc_reg_if rif ();

  logic                  hit_ctrl, hit_stat;
  logic [VPC_DATA_W-1:0] rdata_q;
  logic                  rvalid_q;
  logic [VPC_FLAG_W-1:0] flags_q;

  assign hit_ctrl = (host_addr == VPC_OFS_CTRL);
  assign hit_stat = (host_addr == VPC_OFS_STAT);

  // Status register has no write path at all
  assign rif.wr_en   = host_wr && hit_ctrl; // see (RULE20)
  assign rif.wr_data = host_wdata;

  vpc_ctrl_reg u_ctrl (
    .clk  (clk),
    .rstn (rstn),
    .rif  (rif.ctrl_side)
  );

  vpc_stat_mon u_stat (
    .clk                      (clk),
    .rstn                     (rstn),
    .timing_ref_protect_fault (timing_ref_protect_fault),
    .csum_word_valid          (csum_word_valid),
    .csum_in_check_packet     (csum_in_check_packet),
    .csum_received            (csum_received),
    .csum_computed            (csum_computed),
    .format_unknown           (format_unknown),
    .raster_mismatch          (raster_mismatch),
    .payload_id_absent        (payload_id_absent),
    .pll_locked               (pll_locked),
    .rif                      (rif.stat_side)
  );

  // Read answer one cycle later; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= host_rd;
      if (host_rd) begin
        rdata_q <= hit_ctrl ? rif.ctrl :
                   hit_stat ? rif.stat : 16'h0000;
      end
    end
  end

  assign host_rdata  = rdata_q;
  assign host_rvalid = rvalid_q;

  // Flag source registered so the packet builder sees a clean word
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_q <= '0;
    end else if (rif.ctrl[VPC_B_KEEP_CHECK_FLAGS]) begin
      flags_q <= incoming_check_flags; // see (RULE2)
    end else begin
      flags_q <= programmed_check_flags; // see (RULE2)
    end
  end

  assign outgoing_check_flags = flags_q;

  // Controls taken straight from the register flops
  assign delay_line_on          = rif.ctrl[VPC_B_DELAY_LINE_ON]; // see (RULE1)
  assign keep_incoming_check_flags =
    rif.ctrl[VPC_B_KEEP_CHECK_FLAGS]; // see (RULE2)
  assign ancillary_insert_off   =
    rif.ctrl[VPC_B_ANC_INSERT_OFF]; // see (RULE3)
  assign level_a_to_b_off       =
    rif.ctrl[VPC_B_LEVEL_A_TO_B_OFF]; // see (RULE4)
  assign h_timing_smpte         =
    rif.ctrl[VPC_B_H_TIMING_SMPTE]; // see (RULE5)
  assign payload_id_insert_off  =
    rif.ctrl[VPC_B_PAYLOAD_ID_OFF]; // see (RULE6)
  assign bad_word_fixup_off     =
    rif.ctrl[VPC_B_BAD_WORD_FIXUP_OFF]; // see (RULE7)
  assign error_check_crc_insert_off =
    rif.ctrl[VPC_B_CHECK_CRC_OFF]; // see (RULE8)
  assign ancillary_checksum_insert_off =
    rif.ctrl[VPC_B_ANC_CSUM_OFF]; // see (RULE9)
  assign line_check_word_insert_off =
    rif.ctrl[VPC_B_LINE_CRC_OFF]; // see (RULE10)
  assign line_number_insert_off =
    rif.ctrl[VPC_B_LINE_NUMBER_OFF]; // see (RULE10)
  assign timing_ref_insert_off  =
    rif.ctrl[VPC_B_TIMING_REF_OFF]; // see (RULE11)

endmodule : vpc_regs

`default_nettype wire

// ==== vpc_regs_assertions.sv ====
// Port-level checker for the video processing register bank.
// Assumes inputs stay quiet during reset; bound to every vpc_regs.
`default_nettype none

module vpc_regs_assertions
  import vpc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Host port
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic [11:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic        host_rvalid,
  // Status sources
  input wire logic        timing_ref_protect_fault,
  input wire logic        format_unknown,
  input wire logic        raster_mismatch,
  input wire logic        payload_id_absent,
  // Controls
  input wire logic        delay_line_on,
  input wire logic        level_a_to_b_off,
  input wire logic        h_timing_smpte
);
  wire logic wr_ctl = host_wr && (host_addr == VPC_OFS_CTRL);
  wire logic rd_ctl = host_rd && (host_addr == VPC_OFS_CTRL);
  wire logic rd_stat = host_rd && (host_addr == VPC_OFS_STAT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_delay_line_wr: assert property (
    wr_ctl |=> delay_line_on == $past(host_wdata[14]))
    else $error("delay line control not taken from write");
  a_level_ab_wr: assert property (
    wr_ctl |=> level_a_to_b_off == $past(host_wdata[9]))
    else $error("level conversion control not taken from write");
  a_h_timing_wr: assert property (
    wr_ctl |=> h_timing_smpte == $past(host_wdata[8]))
    else $error("timing select not taken from write");
  a_ctrl_hold: assert property (
    !wr_ctl |=> $stable({delay_line_on, level_a_to_b_off, h_timing_smpte}))
    else $error("controls moved without a control write");
  a_rvalid_pulse: assert property (
    $past(rstn) |-> host_rvalid == $past(host_rd))
    else $error("read valid not one cycle after read");
  a_ctrl_gap_zero: assert property (
    rd_ctl |=> !host_rdata[13])
    else $error("control bit 13 read nonzero");
  a_stat_top_zero: assert property (
    rd_stat |=> host_rdata[15:7] == 9'h000)
    else $error("status upper bits read nonzero");
  a_trs_fault_rd: assert property (
    rd_stat && $past(rstn) |=>
      host_rdata[6] == $past(timing_ref_protect_fault, 2))
    else $error("timing reference fault bit wrong");
  a_stat_levels: assert property (
    rd_stat && $past(rstn) |=> host_rdata[3:1] ==
      $past({format_unknown, raster_mismatch, payload_id_absent}, 2))
    else $error("format, raster or payload status wrong");
endmodule : vpc_regs_assertions

bind vpc_regs vpc_regs_assertions u_chk (.clk, .rstn, .host_wr, .host_rd,
  .host_addr, .host_wdata, .host_rdata, .host_rvalid,
  .timing_ref_protect_fault, .format_unknown, .raster_mismatch,
  .payload_id_absent, .delay_line_on, .level_a_to_b_off, .h_timing_smpte);

`default_nettype wire

// ==== vpc_host_model.sv ====
// Host controller model for the parallel register port.
// Assumes callers wait for each task to return before the next one.
`default_nettype none

module vpc_host_model
  import vpc_pkg::*;
(
  // Clock and answer
  input  wire logic        clk,
  input  wire logic [15:0] host_rdata,
  input  wire logic        host_rvalid,
  // Requests
  output var  logic        host_wr,
  output var  logic        host_rd,
  output var  logic [11:0] host_addr,
  output var  logic [15:0] host_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 12'h000;
    host_wdata = 16'h0000;
  end

  // Released lines show inverted values so stale data never passes
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(negedge clk);
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [15:0] d,
                    output logic v);
    @(negedge clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(negedge clk);
    host_rd <= 1'b0;
    host_addr <= ~a;
    v = host_rvalid;
    d = host_rdata;
  endtask : rd
endmodule : vpc_host_model

`default_nettype wire

// ==== vpc_regs_tb_top.sv ====
// Self-checking bench for the video processing register bank.
// Assumes vpc_host_model drives the host port; video inputs from here.
`default_nettype none

module vpc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vpc_pkg::*;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic host_wr, host_rd, host_rvalid;
  logic [11:0] host_addr;
  logic [15:0] host_wdata, host_rdata;
  logic timing_ref_protect_fault = 0, format_unknown = 0;
  logic raster_mismatch = 0, payload_id_absent = 0, pll_locked = 1;
  logic csum_word_valid = 0, csum_in_check_packet = 0;
  logic [9:0] csum_received = 10'h000, csum_computed = 10'h000;
  logic [14:0] incoming_check_flags = 15'h0000;
  logic [14:0] programmed_check_flags = 15'h0000;
  logic [14:0] outgoing_check_flags;
  logic delay_line_on, keep_incoming_check_flags, ancillary_insert_off;
  logic level_a_to_b_off, h_timing_smpte, payload_id_insert_off;
  logic bad_word_fixup_off, error_check_crc_insert_off;
  logic ancillary_checksum_insert_off, line_check_word_insert_off;
  logic line_number_insert_off, timing_ref_insert_off;
  int fails = 0;
  int n_checks = 0;
  wire logic [11:0] ctl_vec = {delay_line_on, keep_incoming_check_flags,
    ancillary_insert_off, level_a_to_b_off, h_timing_smpte,
    payload_id_insert_off, bad_word_fixup_off, error_check_crc_insert_off,
    ancillary_checksum_insert_off, line_check_word_insert_off,
    line_number_insert_off, timing_ref_insert_off};

  vpc_regs uut (.clk, .rstn, .host_wr, .host_rd, .host_addr, .host_wdata,
    .host_rdata, .host_rvalid, .timing_ref_protect_fault, .csum_word_valid,
    .csum_in_check_packet, .csum_received, .csum_computed, .format_unknown,
    .raster_mismatch, .payload_id_absent, .pll_locked,
    .incoming_check_flags, .programmed_check_flags, .outgoing_check_flags,
    .delay_line_on, .keep_incoming_check_flags, .ancillary_insert_off,
    .level_a_to_b_off, .h_timing_smpte, .payload_id_insert_off,
    .bad_word_fixup_off, .error_check_crc_insert_off,
    .ancillary_checksum_insert_off, .line_check_word_insert_off,
    .line_number_insert_off, .timing_ref_insert_off);
  vpc_host_model host (.clk, .host_rdata, .host_rvalid, .host_wr,
    .host_rd, .host_addr, .host_wdata);

  initial forever #2 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.rd(a, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask : rdc

  // Called on a falling edge or at time zero; three reset edges follow
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (3) @(negedge clk);
    rstn <= 1'b1;
  endtask : do_reset

  task automatic t_reset;
    rdc(VPC_OFS_CTRL, 16'h0200);
    chk({4'h0, ctl_vec}, 16'h0100);
    chk({1'b0, outgoing_check_flags}, 16'h0000);
    rdc(VPC_OFS_STAT, 16'h0000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_ctrl;
    logic [15:0] d;
    for (int i = 0; i < 16; i++) begin
      d = 16'h0001 << i;
      host.wr(VPC_OFS_CTRL, d);
      chk({4'h0, ctl_vec},
          {4'h0, d[14], d[12:11], d[9:8], d[6:0]});
      rdc(VPC_OFS_CTRL, d & 16'hDFFF);
    end
    host.wr(VPC_OFS_CTRL, 16'hFFFF);
    host.wr(VPC_OFS_STAT, 16'h0000);
    host.wr(12'h123, 16'h0000);
    rdc(VPC_OFS_CTRL, 16'hDFFF);
    chk({4'h0, ctl_vec}, 16'h0FFF);
    rdc(12'h123, 16'h0000);
    $display("t_ctrl done");
  endtask : t_ctrl

  task automatic t_flags;
    incoming_check_flags <= 15'h2A5A;
    programmed_check_flags <= 15'h15A5;
    host.wr(VPC_OFS_CTRL, 16'h1000);
    @(negedge clk);
    chk({1'b0, outgoing_check_flags}, 16'h2A5A);
    host.wr(VPC_OFS_CTRL, 16'h0000);
    @(negedge clk);
    chk({1'b0, outgoing_check_flags}, 16'h15A5);
    $display("t_flags done");
  endtask : t_flags

  task automatic t_status;
    int pos[4] = '{6, 3, 2, 1};
    for (int i = 0; i < 4; i++) begin
      {timing_ref_protect_fault, format_unknown, raster_mismatch,
       payload_id_absent} <= 4'h8 >> i;
      rdc(VPC_OFS_STAT, 16'h0001 << pos[i]);
    end
    host.wr(VPC_OFS_STAT, 16'hFFFF);
    rdc(VPC_OFS_STAT, 16'h0002);
    payload_id_absent <= 1'b0;
    pll_locked <= 1'b0;
    repeat (6) @(negedge clk);
    rdc(VPC_OFS_STAT, 16'h0001);
    pll_locked <= 1'b1;
    repeat (6) @(negedge clk);
    rdc(VPC_OFS_STAT, 16'h0000);
    $display("t_status done");
  endtask : t_status

  task automatic sum(input logic [9:0] r, input logic [9:0] c,
                     input logic p, input logic [15:0] exp);
    @(negedge clk);
    csum_word_valid <= 1'b1;
    csum_received <= r;
    csum_computed <= c;
    csum_in_check_packet <= p;
    @(negedge clk);
    csum_word_valid <= 1'b0;
    rdc(VPC_OFS_STAT, exp);
  endtask : sum

  task automatic t_csum;
    sum(10'h100, 10'h101, 1'b0, 16'h0010);
    sum(10'h100, 10'h101, 1'b1, 16'h0030);
    sum(10'h100, 10'h100, 1'b0, 16'h0020);
    sum(10'h004, 10'h100, 1'b1, 16'h0030);
    sum(10'h003, 10'h100, 1'b1, 16'h0000);
    sum(10'h3FB, 10'h100, 1'b1, 16'h0030);
    sum(10'h3FC, 10'h100, 1'b0, 16'h0020);
    sum(10'h3FF, 10'h100, 1'b1, 16'h0000);
    $display("t_csum done");
  endtask : t_csum

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // Whole run is well under a thousand cycles
  initial begin
    #40000;
    fails++;
    conclude();
  end

  initial begin
    do_reset();
    t_reset();
    t_ctrl();
    do_reset();
    t_reset();
    t_flags();
    t_status();
    t_csum();
    conclude();
  end
endmodule : vpc_regs_tb_top

`default_nettype wire
